// *** src/eos_seq_pkg.sv ***
/*
  Shared types and constants of the transmit end-of-stream sequencer.
  Assumes it is compiled ahead of every file that imports it.
*/
package eos_seq_pkg;

  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int unsigned NIBBLE_W     = 4;
  localparam logic [3:0]  DATA_RST     = 4'h0;
  localparam logic        ERR_RST      = 1'b0;
  localparam logic        BUSY_RST     = 1'b0;
  localparam logic        RST_SYNC_RST = 1'b0;

  // ****************************************************************
  // Transmit states, one-hot
  // ****************************************************************
  typedef enum logic [7:0] {
    st_idle        = 8'h01,
    st_start_a     = 8'h02,
    st_start_b     = 8'h04,
    st_start_c     = 8'h08,
    st_data        = 8'h10,
    st_end_delim_a = 8'h20,
    st_end_delim_b = 8'h40,
    st_end_delim_c = 8'h80
  } tx_state_t;

  // ****************************************************************
  // Line symbol kinds handed to the ternary mapper
  // ****************************************************************
  typedef enum logic [3:0] {
    sym_idle              = 4'h0,
    start_delim_sym_a     = 4'h1,
    start_delim_sym_b     = 4'h2,
    start_delim_sym_c     = 4'h3,
    sym_data              = 4'h4,
    end_delim_sym_a       = 4'h5,
    end_delim_sym_b       = 4'h6,
    end_delim_sym_c       = 4'h7,
    end_delim_sym_c_error = 4'h8
  } line_sym_t;

endpackage

// *** src/eos_sym_select.sv ***
/*
  Maps a transmit state and the frame error flag to the line symbol kind.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ps

module eos_sym_select
  import eos_seq_pkg::*;
(
  input  wire tx_state_t state,
  input  wire logic      frame_err,
  output line_sym_t      sym
);

  // ****************************************************************
  // Symbol decode
  // ****************************************************************

  // Third end symbol takes its error form when the frame was marked bad
  wire line_sym_t end_c_sym = frame_err ? end_delim_sym_c_error : end_delim_sym_c;

  // One symbol per state
  always_comb begin
    case (state)
      st_idle:        sym = sym_idle;
      st_start_a:     sym = start_delim_sym_a;
      st_start_b:     sym = start_delim_sym_b;
      st_start_c:     sym = start_delim_sym_c;
      st_data:        sym = sym_data;
      st_end_delim_a: sym = end_delim_sym_a;
      st_end_delim_b: sym = end_delim_sym_b;
      st_end_delim_c: sym = end_c_sym;
      default:        sym = sym_idle;
    endcase
  end

endmodule

// *** src/pcs_tx_end_delimiter_sequencer.sv ***
/*
  Transmit sequencer of a single-pair 100 Mbit/s PCS: idle, start delimiters,
  data, and the fixed three-symbol end of stream, then idle again.
  Assumes the MII transmit signals come from logic on the same clock, and that
  clk runs while rstn is low so the synchronous state reset can take hold.
*/
`timescale 1ns/1ps

// Function
// - First end state sends symbol a, then goes to the second, ignoring MII.
// - Second end state sends symbol b, then goes to the third, ignoring MII.
// - Third end state sends symbol c, then goes straight to idle sending.
// - The three end states advance unconditionally; MII activity cannot shorten them.
// - Enable falling in data gives end symbol a, then end symbol b.
// - Enable low for one clock then high still completes the whole end sequence.
// - Frame without error ends with the normal third end symbol after a and b.
// - After the end symbols, idle symbols continue while enable stays low.
// - Data state keeps encoding data until enable goes low.
// - A frame starts with the three start symbols before the data state.
// - An error during the frame turns the third end symbol into its error form.
module pcs_tx_end_delimiter_sequencer
  import eos_seq_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          rstn,
  input  wire logic                          tx_en,
  input  wire logic                          tx_er,
  input  wire logic [eos_seq_pkg::NIBBLE_W-1:0] txd,
  output eos_seq_pkg::line_sym_t             sym_q,
  output logic [eos_seq_pkg::NIBBLE_W-1:0]    data_q,
  output logic                               busy_q
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta_q;
  logic rst_sync_q;

  // Asserts at once, releases after two edges to avoid a metastable release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= RST_SYNC_RST;
      rst_sync_q <= RST_SYNC_RST;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ****************************************************************
  // Next-state decode
  // ****************************************************************
  tx_state_t st_q;
  tx_state_t st_d;
  logic      err_q;
  logic      err_d;
  line_sym_t sym_d;

  wire frame_start = (st_q == st_idle) && tx_en;
  wire data_end    = (st_q == st_data) && !tx_en;
  wire in_frame    = (st_q == st_start_a) || (st_q == st_start_b) ||
                     (st_q == st_start_c) || (st_q == st_data);

  // End states never look at the MII; that is what keeps the tail whole
  always_comb begin
    case (st_q)
      st_idle:        st_d = tx_en ? st_start_a : st_idle;
      st_start_a:     st_d = st_start_b;
      st_start_b:     st_d = st_start_c;
      st_start_c:     st_d = st_data;
      st_data:        st_d = tx_en ? st_data : st_end_delim_a;
      st_end_delim_a: st_d = st_end_delim_b;
      st_end_delim_b: st_d = st_end_delim_c;
      st_end_delim_c: st_d = st_idle;
      default:        st_d = st_idle;
    endcase
  end

  // Error flag: a fresh frame restarts it, but an error in that same cycle still counts
  assign err_d = frame_start ? tx_er : (err_q | (in_frame & tx_en & tx_er));

  eos_sym_select u_sym_select (
    .state     (st_d),
    .frame_err (err_d),
    .sym       (sym_d)
  );

  // ****************************************************************
  // State and output registers
  // ****************************************************************

  // Synchronous reset from the released copy; outputs line up with the state
  always_ff @(posedge clk) begin
    if (!rst_sync_q) begin
      st_q   <= st_idle;
      err_q  <= ERR_RST;
      sym_q  <= sym_idle;
      data_q <= DATA_RST;
      busy_q <= BUSY_RST;
    end else begin
      st_q   <= st_d;
      err_q  <= err_d;
      sym_q  <= sym_d;
      data_q <= (st_d == st_data) ? txd : DATA_RST; // Nibble rides with data symbols only
      busy_q <= (st_d != st_idle);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_end_a_step;
    @(posedge clk) disable iff (!rst_sync_q)
      (st_q == st_end_delim_a) |-> (sym_q == end_delim_sym_a) ##1
                                   (st_q == st_end_delim_b);
  endproperty
  a_end_a_step: assert property (p_end_a_step) else $error("end a did not lead to end b");

  property p_end_b_step;
    @(posedge clk) disable iff (!rst_sync_q)
      (st_q == st_end_delim_b) |-> (sym_q == end_delim_sym_b) ##1
                                   (st_q == st_end_delim_c);
  endproperty
  a_end_b_step: assert property (p_end_b_step) else $error("end b did not lead to end c");

  property p_end_c_step;
    @(posedge clk) disable iff (!rst_sync_q)
      (st_q == st_end_delim_c) |=> (st_q == st_idle) && (sym_q == sym_idle);
  endproperty
  a_end_c_step: assert property (p_end_c_step) else $error("end c did not return to idle");

  property p_tail_whole;
    @(posedge clk) disable iff (!rst_sync_q)
      $rose(st_q == st_end_delim_a) |-> busy_q [*3] ##1 !busy_q;
  endproperty
  a_tail_whole: assert property (p_tail_whole) else $error("end sequence length wrong");

  property p_data_exit;
    @(posedge clk) disable iff (!rst_sync_q)
      data_end |=> (sym_q == end_delim_sym_a) ##1 (sym_q == end_delim_sym_b);
  endproperty
  a_data_exit: assert property (p_data_exit) else $error("enable drop gave wrong symbols");

  property p_short_gap;
    @(posedge clk) disable iff (!rst_sync_q)
      (data_end ##1 tx_en) |-> (st_q == st_end_delim_a) ##1 (st_q == st_end_delim_b)
                               ##1 (st_q == st_end_delim_c);
  endproperty
  a_short_gap: assert property (p_short_gap) else $error("short enable gap cut the tail");

  property p_clean_end;
    @(posedge clk) disable iff (!rst_sync_q)
      (st_q == st_end_delim_c) && !err_q |-> (sym_q == end_delim_sym_c) &&
        ($past(sym_q, 1) == end_delim_sym_b) && ($past(sym_q, 2) == end_delim_sym_a);
  endproperty
  a_clean_end: assert property (p_clean_end) else $error("clean frame end symbols wrong");

  property p_idle_hold;
    @(posedge clk) disable iff (!rst_sync_q)
      (st_q == st_idle) && !tx_en |=> (sym_q == sym_idle) && !busy_q;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle not kept while enable low");

  property p_data_stay;
    @(posedge clk) disable iff (!rst_sync_q)
      (st_q == st_data) && tx_en |=> (sym_q == sym_data) && (data_q == $past(txd));
  endproperty
  a_data_stay: assert property (p_data_stay) else $error("data state left or data lost");

  property p_start_seq;
    @(posedge clk) disable iff (!rst_sync_q)
      frame_start |=> (sym_q == start_delim_sym_a) ##1 (sym_q == start_delim_sym_b)
                      ##1 (sym_q == start_delim_sym_c) ##1 (st_q == st_data);
  endproperty
  a_start_seq: assert property (p_start_seq) else $error("start delimiters wrong");

  property p_err_end;
    @(posedge clk) disable iff (!rst_sync_q)
      (st_q == st_end_delim_c) && err_q |-> (sym_q == end_delim_sym_c_error);
  endproperty
  a_err_end: assert property (p_err_end) else $error("error frame lacks error end");

  property p_rst_idle;
    @(posedge clk) disable iff (!rstn)
      $rose(rst_sync_q) |-> (st_q == st_idle) && (sym_q == sym_idle) && !busy_q;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("not idle on reset release");

  // Main scenarios
  c_clean_frame: cover property (@(posedge clk) disable iff (!rst_sync_q)
    (st_q == st_end_delim_c) && !err_q);
  c_err_frame: cover property (@(posedge clk) disable iff (!rst_sync_q)
    (st_q == st_end_delim_c) && err_q);
  c_short_gap: cover property (@(posedge clk) disable iff (!rst_sync_q)
    data_end ##1 tx_en);
  c_back_to_back: cover property (@(posedge clk) disable iff (!rst_sync_q)
    (st_q == st_end_delim_c) ##1 frame_start);

endmodule

// *** verif/mii_mac_model.sv ***
/*
  MAC model that drives the MII transmit side of the sequencer.
  Assumes it shares the clock of the sequencer and drives just after rising edges.
*/
`timescale 1ns/1ps

module mii_mac_model (
  input  wire logic       clk,
  output logic            tx_en,
  output logic            tx_er,
  output logic [3:0]      txd
);
  // Quiet bus before any frame so the link comes up clean
  initial begin
    tx_en = 1'b0;
    tx_er = 1'b0;
    txd   = 4'h0;
  end

  // One frame of n nibbles, then gap cycles; noise stirs txd and tx_er through the whole gap, tx_en from its second gap cycle on
  task automatic send(input int n, input bit er, input int gap, input bit noise);
    for (int i = 0; i < n + gap; i++) begin
      @(posedge clk);
      tx_en <= (i < n) || (noise && i > n && 1'($urandom));
      tx_er <= (i < n) ? er : (noise && 1'($urandom));
      txd   <= (i < n || noise) ? 4'($urandom) : 4'h0;
    end
  endtask
endmodule

// *** verif/pcs_tx_end_delimiter_sequencer_tb_top.sv ***
/*
  Self-checking bench: MAC model drives the sequencer, a cycle model predicts every output.
  Assumes the design package is compiled first; no other surroundings are needed.
*/
`timescale 1ns/1ps

module pcs_tx_end_delimiter_sequencer_tb_top;
  import eos_seq_pkg::*;

  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        tx_en;
  logic        tx_er;
  logic [3:0]  txd;
  line_sym_t   sym_q;
  logic [3:0]  data_q;
  logic        busy_q;
  int          errors = 0;
  int          n_tests = 0;
  bit          go = 1'b0;
  int          st = 0;
  int          nx = 0;
  int          err = 0;
  int          s1 = 0;
  int          s2 = 0;
  logic [3:0]  e_sym = 4'h0;
  logic [3:0]  e_data = 4'h0;
  logic        e_busy = 1'b0;

  // 250 MHz transmit clock
  always #2 clk = ~clk;

  mii_mac_model mac (.clk(clk), .tx_en(tx_en), .tx_er(tx_er), .txd(txd));

  pcs_tx_end_delimiter_sequencer dut (
    .clk(clk), .rstn(rstn), .tx_en(tx_en), .tx_er(tx_er), .txd(txd),
    .sym_q(sym_q), .data_q(data_q), .busy_q(busy_q)
  );

  // ****************************************************************
  // Reference model; state numbers equal the symbol codes
  // ****************************************************************
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1 = 0;
      s2 = 0;
    end else begin
      nx = 0;
      if (s2 != 0) begin
        case (st)
          0: begin
            if (tx_en) err = tx_er; // Start cycle may already mark the frame
            nx = tx_en ? 1 : 0;
          end
          1, 2, 3: begin
            err |= tx_en && tx_er;
            nx = st + 1;
          end
          4: begin
            err |= tx_en && tx_er;
            nx = tx_en ? 4 : 5;
          end
          5, 6: nx = st + 1; // MII ignored while ending
          default: nx = 0;
        endcase
      end
      e_sym  = (nx == 7 && err != 0) ? 4'h8 : 4'(nx);
      e_data = (nx == 4) ? txd : 4'h0;
      e_busy = (nx != 0);
      st = nx;
      s2 = s1;
      s1 = 1;
    end
  end

  task automatic note(input bit bad, input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (bad) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_sym(input line_sym_t got, input logic [3:0] exp);
    note(got !== line_sym_t'(exp), got, exp);
  endtask

  task automatic chk_data(input logic [3:0] got, input logic [3:0] exp);
    note(got !== exp, got, exp);
  endtask

  task automatic chk_busy(input logic got, input logic exp);
    note(got !== exp, {3'h0, got}, {3'h0, exp});
  endtask

  // Outputs are settled mid-cycle, so compare on the falling edge
  always @(negedge clk) begin
    if (go) begin
      chk_sym(sym_q, e_sym);
      chk_data(data_q, e_data);
      chk_busy(busy_q, e_busy);
    end
  end

  task automatic wrap_up();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Run is about 400 cycles; this cuts a hang well after that
  initial begin
    #100000;
    errors++;
    wrap_up();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(32'h0555));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    go = 1'b1;
    mac.send(6, 1'b0, 2, 1'b0);
    mac.send(5, 1'b0, 1, 1'b0);
    mac.send(3, 1'b0, 2, 1'b0);
    mac.send(8, 1'b0, 3, 1'b0);
    mac.send(1, 1'b0, 8, 1'b0);
    mac.send(6, 1'b1, 2, 1'b0);
    mac.send(5, 1'b1, 1, 1'b1);
    for (int i = 0; i < 40; i++) begin
      mac.send(1 + $urandom_range(7), $urandom_range(1), 1 + $urandom_range(5),
               $urandom_range(1));
    end
    repeat (12) @(posedge clk);
    wrap_up();
  end
endmodule
